//--- pkg/ufp_pkg.sv
// Purpose: constants for the usb function power control block
// Assumes: apb slave, 32-bit data, 8-bit register in low bits
// Notes: one power control register, one irq flags register, one irq enable register
package ufp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] POWER_IDX = 8'h01;
  localparam logic [7:0] PWR_CFG_IDX = 8'h10;
  localparam logic [11:0] POWER_ADDR = 12'h004;
  localparam logic [11:0] COMMON_IRQ_FLAGS_RD_ADDR = 12'h040;
  localparam logic [11:0] IRQ_EN_ADDR = 12'h044;
  // power control fields
  localparam int BIT_ISO = 7;
  localparam int BIT_INH = 4;
  localparam int BIT_RST = 3;
  localparam int BIT_RES = 2;
  localparam int BIT_SUS = 1;
  localparam int BIT_SEN = 0;
  localparam logic [7:0] POWER_RESET = 8'h10;
  // irq enable fields: suspend, resume, reset
  localparam int EN_SUS = 2;
  localparam int EN_RES = 1;
  localparam int EN_RST = 0;
  localparam logic [2:0] IRQ_EN_RESET = 3'h6;
  localparam logic [2:0] IRQ_EN_BUSRST = 3'h3;
  localparam int ZERO_IDX = 0;
endpackage : ufp_pkg

//--- src/ufp_sync_rst.sv
// Purpose: software forced asynchronous reset generator
// Assumes: presetn asynchronous active low
// Notes: holds function reset low for two cycles after request
`timescale 1ns/1ps
module ufp_sync_rst (
  input wire logic pclk, // clock
  input wire logic presetn, // power-on reset
  input wire logic req, // one-cycle request
  output logic func_rstn // combined function reset
);
  typedef struct packed {
    logic [1:0] cnt_r;
  } ufp_rst_st_t;
  ufp_rst_st_t s_r;
  ufp_rst_st_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (req) begin
      s_nxt.cnt_r = 2'h2;
    end else if (s_r.cnt_r != 2'h0) begin
      s_nxt.cnt_r = s_r.cnt_r - 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign func_rstn = presetn & (s_r.cnt_r == 2'h0);
endmodule : ufp_sync_rst

//--- src/ufp_power_ctrl.sv
// Purpose: usb function power control: enable, bus reset, suspend, resume, iso gating
// Assumes: apb slave on pclk; bus events arrive as synchronous one-cycle pulses
// Notes: function reset returns every register to default at the clock edge after request and holds it there two cycles
// Operation
// - bus reset detection sets the reset-detect status bit
// - bus reset clears address, flushes fifos, clears endpoint and index regs
// - bus reset enables all irqs except suspend and clears their flags
// - bus reset raises reset interrupt whatever the reset enable bit holds
// - writing one to reset-detect bit forces asynchronous function reset
// - suspend signaling with detection enabled enters suspend and sets status
// - entering suspend raises suspend interrupt when enabled
// - resume, bus reset or function reset ends suspend mode
// - resume or bus reset wakes the oscillator while suspended; function reset does not
// - detected bus resume raises resume interrupt when enabled
// - writing force-resume while suspended drives remote wakeup signaling
// - clearing force-resume after wakeup raises interrupt and clears suspend
// - reading common flags after bus resume clears suspend status
// - iso update holds new iso in packets until next sof
// - iso in token before sof gets zero-length packet
// - function disabled after power-on with inhibit set until cleared
// - writes of one to inhibit ignored; only resets set it again
// - power register resets to inhibit only; suspend bit read-only
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module ufp_power_ctrl (
  input wire logic pclk, // clock
  input wire logic presetn, // power-on reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic bus_reset_seen, // bus reset signaling pulse
  input wire logic bus_suspend_seen, // suspend signaling pulse
  input wire logic bus_resume_seen, // resume signaling pulse
  input wire logic sof_seen, // start of frame pulse
  input wire logic iso_in_loaded, // in_packet_loaded on iso endpoint
  input wire logic iso_in_token, // in token on iso endpoint
  output logic function_enabled, // function not inhibited
  output logic endpoint_clear, // address, fifo, csr, index clear pulse
  output logic remote_wakeup_drive, // drive resume signaling
  output logic osc_wake, // oscillator suspend exit pulse
  output logic iso_send_packet, // send loaded iso packet
  output logic iso_send_zlp, // send zero-length packet
  output logic usb_irq, // combined interrupt level
  output logic func_rstn // function reset, active low
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] power_r;
    logic [2:0] irq_en_r;
    logic [3:0] flags_r; // wakeup, suspend, resume, reset
    logic pending_r;
    logic woke_r;
    logic bus_resumed_r;
    logic clr_r;
    logic osc_r;
    logic send_r;
    logic zlp_r;
    logic [31:0] rdata_r;
  } ufp_state_t;
  ufp_state_t s_r;
  ufp_state_t s_nxt;
  logic wr;
  logic rd;
  logic soft_rst;
  logic suspended;
  logic exit_ev;
  logic [7:0] wbyte;
  logic wr_power;
  logic rd_flags;

  // ==========================================================
  // apb decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction : hit
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit(paddr, ufp_pkg::POWER_ADDR)
    | hit(paddr, ufp_pkg::COMMON_IRQ_FLAGS_RD_ADDR) | hit(paddr, ufp_pkg::IRQ_EN_ADDR));
  assign soft_rst = wr & hit(paddr, ufp_pkg::POWER_ADDR) & wbyte[ufp_pkg::BIT_RST];
  assign suspended = s_r.power_r[ufp_pkg::BIT_SUS];
  assign wr_power = wr & hit(paddr, ufp_pkg::POWER_ADDR);
  assign rd_flags = rd & hit(paddr, ufp_pkg::COMMON_IRQ_FLAGS_RD_ADDR);

  ufp_sync_rst u_rst (
    .pclk(pclk),
    .presetn(presetn),
    .req(soft_rst),
    .func_rstn(func_rstn)
  );

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.clr_r = 1'b0;
    s_nxt.osc_r = 1'b0;
    s_nxt.send_r = 1'b0;
    s_nxt.zlp_r = 1'b0;
    exit_ev = 1'b0;
    // register writes
    if (wr && hit(paddr, ufp_pkg::POWER_ADDR)) begin
      s_nxt.power_r[ufp_pkg::BIT_ISO] = wbyte[ufp_pkg::BIT_ISO];
      s_nxt.power_r[ufp_pkg::BIT_SEN] = wbyte[ufp_pkg::BIT_SEN];
      if (!wbyte[ufp_pkg::BIT_INH]) begin
        s_nxt.power_r[ufp_pkg::BIT_INH] = 1'b0;
      end
      if (wbyte[ufp_pkg::BIT_RES] && suspended) begin
        s_nxt.power_r[ufp_pkg::BIT_RES] = 1'b1;
        s_nxt.woke_r = 1'b1;
        exit_ev = 1'b1;
      end else if (!wbyte[ufp_pkg::BIT_RES] && s_r.power_r[ufp_pkg::BIT_RES]) begin
        s_nxt.power_r[ufp_pkg::BIT_RES] = 1'b0;
        if (s_r.woke_r) begin
          s_nxt.power_r[ufp_pkg::BIT_SUS] = 1'b0;
          s_nxt.flags_r[3] = 1'b1;
          s_nxt.woke_r = 1'b0;
        end
      end
    end
    if (wr && hit(paddr, ufp_pkg::IRQ_EN_ADDR)) begin
      s_nxt.irq_en_r = wbyte[2:0];
    end
    // reading flags clears them, suspend cleared after bus resume
    if (rd && hit(paddr, ufp_pkg::COMMON_IRQ_FLAGS_RD_ADDR)) begin
      s_nxt.flags_r = 4'h0;
      if (s_r.bus_resumed_r) begin
        s_nxt.power_r[ufp_pkg::BIT_SUS] = 1'b0;
        s_nxt.bus_resumed_r = 1'b0;
      end
    end
    // suspend entry
    if (bus_suspend_seen && s_r.power_r[ufp_pkg::BIT_SEN] && !suspended) begin
      s_nxt.power_r[ufp_pkg::BIT_SUS] = 1'b1;
      if (s_r.irq_en_r[ufp_pkg::EN_SUS]) begin
        s_nxt.flags_r[2] = 1'b1;
      end
    end
    // bus resume
    if (bus_resume_seen) begin
      if (suspended) begin
        s_nxt.bus_resumed_r = 1'b1;
        exit_ev = 1'b1;
      end
      if (s_r.irq_en_r[ufp_pkg::EN_RES]) begin
        s_nxt.flags_r[1] = 1'b1;
      end
    end
    // bus reset
    if (bus_reset_seen) begin
      s_nxt.power_r[ufp_pkg::BIT_RST] = 1'b1;
      s_nxt.power_r[ufp_pkg::BIT_SUS] = 1'b0;
      s_nxt.power_r[ufp_pkg::BIT_RES] = 1'b0;
      s_nxt.woke_r = 1'b0;
      s_nxt.bus_resumed_r = 1'b0;
      s_nxt.clr_r = 1'b1;
      s_nxt.irq_en_r = ufp_pkg::IRQ_EN_BUSRST;
      s_nxt.flags_r = 4'h1;
      exit_ev = exit_ev | suspended;
    end
    if (exit_ev && suspended) begin
      s_nxt.osc_r = 1'b1;
    end
    // iso update gating
    if (iso_in_loaded) begin
      s_nxt.pending_r = 1'b1;
    end
    if (!s_r.power_r[ufp_pkg::BIT_ISO]) begin
      s_nxt.send_r = iso_in_token & s_r.pending_r;
      if (iso_in_token) begin
        s_nxt.pending_r = iso_in_loaded;
      end
    end else if (iso_in_token) begin
      s_nxt.zlp_r = 1'b1;
    end else if (sof_seen && s_r.pending_r) begin
      s_nxt.send_r = 1'b1;
      s_nxt.pending_r = iso_in_loaded;
    end
    // read data
    s_nxt.rdata_r = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (hit(paddr, ufp_pkg::POWER_ADDR)) begin
        s_nxt.rdata_r = {24'h00_0000, s_r.power_r};
      end else if (hit(paddr, ufp_pkg::COMMON_IRQ_FLAGS_RD_ADDR)) begin
        s_nxt.rdata_r = {28'h000_0000, s_r.flags_r};
      end else if (hit(paddr, ufp_pkg::IRQ_EN_ADDR)) begin
        s_nxt.rdata_r = {29'h0000_0000, s_r.irq_en_r};
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge func_rstn) begin
    if (!func_rstn) begin
      s_r <= '0;
      s_r.power_r <= ufp_pkg::POWER_RESET;
      s_r.irq_en_r <= ufp_pkg::IRQ_EN_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = s_r.rdata_r;
  assign function_enabled = ~s_r.power_r[ufp_pkg::BIT_INH];
  assign endpoint_clear = s_r.clr_r;
  assign remote_wakeup_drive = s_r.power_r[ufp_pkg::BIT_RES];
  assign osc_wake = s_r.osc_r;
  assign iso_send_packet = s_r.send_r;
  assign iso_send_zlp = s_r.zlp_r;
  assign usb_irq = |s_r.flags_r;

  // ==========================================================
  // checks
  inhibit_sticky_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    !s_r.power_r[ufp_pkg::BIT_INH] |=> !s_r.power_r[ufp_pkg::BIT_INH])
    else $error("inhibit bit set again without reset");
  reset_status_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    bus_reset_seen |=> s_r.power_r[ufp_pkg::BIT_RST] && endpoint_clear && usb_irq)
    else $error("bus reset not recorded");
  reset_irqen_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    bus_reset_seen |=> s_r.irq_en_r == ufp_pkg::IRQ_EN_BUSRST)
    else $error("irq enables wrong after bus reset");
  suspend_enter_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (bus_suspend_seen && !s_r.power_r[ufp_pkg::BIT_SEN] && !suspended)
    |=> !suspended)
    else $error("suspend entered while detection disabled");
  bus_reset_wake_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    bus_reset_seen |=> !suspended)
    else $error("suspend held across bus reset");
  osc_wake_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (suspended && bus_reset_seen) |=> osc_wake)
    else $error("oscillator not woken");
  resume_drive_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (soft_rst == 1'b0 && wr && hit(paddr, ufp_pkg::POWER_ADDR) && wbyte[ufp_pkg::BIT_RES]
    && suspended && !bus_reset_seen) |=> remote_wakeup_drive)
    else $error("remote wakeup not driven");
  iso_zlp_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (s_r.power_r[ufp_pkg::BIT_ISO] && iso_in_token) |=> iso_send_zlp && !iso_send_packet)
    else $error("iso token before sof not answered empty");
  soft_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    soft_rst |=> ##1 !func_rstn)
    else $error("forced reset not applied");

  // ==========================================================
  // bus reset side effects
  reset_clear_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    bus_reset_seen |=> endpoint_clear)
    else $error("endpoint clear missing after bus reset");

  clear_cause_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    endpoint_clear |-> $past(bus_reset_seen))
    else $error("endpoint clear without bus reset");

  reset_flags_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    bus_reset_seen |=> s_r.flags_r == 4'h1)
    else $error("flags not cleared on bus reset");

  reset_irq_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    bus_reset_seen |=> s_r.flags_r[0])
    else $error("reset interrupt missing");

  reset_sticky_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    s_r.power_r[ufp_pkg::BIT_RST] |=> s_r.power_r[ufp_pkg::BIT_RST])
    else $error("reset detect status lost");

  // ==========================================================
  // suspend and resume
  suspend_set_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (bus_suspend_seen && s_r.power_r[ufp_pkg::BIT_SEN] && !suspended && !bus_reset_seen)
    |=> suspended)
    else $error("suspend not entered");

  suspend_irq_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (bus_suspend_seen && s_r.power_r[ufp_pkg::BIT_SEN] && !suspended && !bus_reset_seen
    && s_r.irq_en_r[ufp_pkg::EN_SUS]) |=> s_r.flags_r[2])
    else $error("suspend interrupt missing");

  resume_irq_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (bus_resume_seen && s_r.irq_en_r[ufp_pkg::EN_RES] && !bus_reset_seen)
    |=> s_r.flags_r[1])
    else $error("resume interrupt missing");

  resume_osc_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (suspended && bus_resume_seen) |=> osc_wake)
    else $error("oscillator not woken on resume");

  wakeup_osc_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (suspended && wr_power && wbyte[ufp_pkg::BIT_RES] && !soft_rst) |=> osc_wake)
    else $error("oscillator not woken on remote wakeup");

  osc_cause_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    osc_wake |-> $past(suspended))
    else $error("oscillator woken while awake");

  wake_done_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (wr_power && !wbyte[ufp_pkg::BIT_RES] && s_r.power_r[ufp_pkg::BIT_RES] && s_r.woke_r
    && !soft_rst && !bus_reset_seen) |=> !suspended && s_r.flags_r[3])
    else $error("wakeup end not handled");

  resume_read_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (rd_flags && s_r.bus_resumed_r && !bus_suspend_seen) |=> !suspended)
    else $error("suspend kept after flags read");

  suspend_hold_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (suspended && !bus_reset_seen && !rd_flags && !wr_power) |=> suspended)
    else $error("suspend status changed without cause");

  wakeup_gate_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (!remote_wakeup_drive && !suspended) |=> !remote_wakeup_drive)
    else $error("remote wakeup while awake");

  // ==========================================================
  // iso gating
  iso_sof_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (s_r.power_r[ufp_pkg::BIT_ISO] && !iso_in_token && sof_seen && s_r.pending_r)
    |=> iso_send_packet)
    else $error("iso packet not sent on sof");

  iso_hold_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (s_r.power_r[ufp_pkg::BIT_ISO] && !sof_seen) |=> !iso_send_packet)
    else $error("iso packet sent before sof");

  iso_direct_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    (!s_r.power_r[ufp_pkg::BIT_ISO] && iso_in_token && s_r.pending_r)
    |=> iso_send_packet)
    else $error("iso packet not sent on token");

  zlp_cause_a: assert property (@(posedge pclk) disable iff (!func_rstn)
    iso_send_zlp |-> $past(iso_in_token))
    else $error("empty packet without token");
endmodule : ufp_power_ctrl

//--- sim/ufp_host_model.sv
// Purpose: usb host stand-in driving bus event pulses
// Assumes: bench requests one event at a time, one cycle long
// Notes: every line is low outside a requested event
`timescale 1ns/1ps
module ufp_host_model (
  input wire logic pclk, // clock
  input wire logic presetn, // power-on reset
  input wire logic [4:0] ev, // reset, suspend, resume, sof, token
  output logic bus_reset_seen, // reset signaling
  output logic bus_suspend_seen, // suspend signaling
  output logic bus_resume_seen, // resume signaling
  output logic sof_seen, // start of frame
  output logic iso_in_token // iso in token
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {bus_reset_seen, bus_suspend_seen, bus_resume_seen, sof_seen, iso_in_token} <= 5'h0;
    end else begin
      {bus_reset_seen, bus_suspend_seen, bus_resume_seen, sof_seen, iso_in_token} <= ev;
    end
  end
endmodule : ufp_host_model

//--- sim/tb_usb_function_power_control.sv
// Purpose: self-checking bench for the usb function power control block
// Assumes: zero-wait apb slave, host events as one-cycle pulses
// Notes: register state modelled in exp_pwr, output pulses counted in cnt
`timescale 1ns/1ps
module tb_usb_function_power_control;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lfsr;
  logic fen, epc, rwd, osc, isp, isz, irq, frst, bre, bsu, brs, sof, tok;
  logic [5:0] ev;
  int n_fail, n_tests, exp_pwr;
  int cnt [5] = '{default: 0};
  int base [5];
  ufp_host_model HOST (.pclk(pclk), .presetn(presetn), .ev(ev[4:0]), .bus_reset_seen(bre),
    .bus_suspend_seen(bsu), .bus_resume_seen(brs), .sof_seen(sof), .iso_in_token(tok));
  ufp_power_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_reset_seen(bre), .bus_suspend_seen(bsu), .bus_resume_seen(brs),
    .sof_seen(sof), .iso_in_loaded(ev[5]), .iso_in_token(tok), .function_enabled(fen),
    .endpoint_clear(epc), .remote_wakeup_drive(rwd), .osc_wake(osc), .iso_send_packet(isp),
    .iso_send_zlp(isz), .usb_irq(irq), .func_rstn(frst));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cnt[0] <= cnt[0] + 32'(epc);
    cnt[1] <= cnt[1] + 32'(osc);
    cnt[2] <= cnt[2] + 32'(isp);
    cnt[3] <= cnt[3] + 32'(isz);
    cnt[4] <= cnt[4] + 32'(!frst);
  end
  // ==========================================
  // tasks
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    n_tests++;
    if (got !== e) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int t;
    t = 0;
    lfsr = nxt(lfsr);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {lfsr[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wp(input logic [7:0] d);
    int n;
    apb(1'b1, ufp_pkg::POWER_ADDR, d);
    n = (d & 'h81) | (exp_pwr & d & 'h10) | (exp_pwr & 'h0a);
    if (exp_pwr[1]) n |= d & 'h04;
    if (exp_pwr[2] && !d[2]) n &= 'hfd;
    if (d[3]) n = 'h10;
    exp_pwr = n;
    if (d[3]) repeat (4) @(posedge pclk);
  endtask : wp
  task automatic rp;
    apb(1'b0, ufp_pkg::POWER_ADDR, 8'h00);
    chk(rd, exp_pwr);
  endtask : rp
  task automatic rf(input logic [31:0] e);
    apb(1'b0, ufp_pkg::COMMON_IRQ_FLAGS_RD_ADDR, 8'h00);
    chk(rd, e);
  endtask : rf
  task automatic host(input int b);
    @(posedge pclk);
    ev <= 6'h01 << b;
    @(posedge pclk);
    ev <= 6'h00;
    repeat (3) @(posedge pclk);
  endtask : host
  task automatic pc(input int i, input int n);
    chk(32'(cnt[i] - base[i]), 32'(n));
  endtask : pc
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #(4000 * 50);
    n_fail++;
    wrap_up();
  end
  // ==========================================
  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ev = 6'h00;
    lfsr = 32'h0000_39e0;
    n_fail = 0;
    n_tests = 0;
    exp_pwr = 'h10;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rp();
    chk(32'(fen), 32'h0);
    base = cnt;
    wp(8'h08);
    pc(4, 2);
    rp();
    wp(8'h11);
    wp(8'h01);
    chk(32'(fen), 32'h1);
    wp(8'h11);
    rp();
    apb(1'b1, ufp_pkg::IRQ_EN_ADDR, 8'h07);
    host(3);
    exp_pwr |= 'h02;
    rp();
    chk(32'(irq), 32'h1);
    rf(32'h4);
    base = cnt;
    host(2);
    pc(1, 1);
    rf(32'h2);
    exp_pwr &= 'hfd;
    rp();
    host(3);
    rf(32'h4);
    wp(8'h05);
    chk(32'(rwd), 32'h1);
    wp(8'h01);
    rp();
    rf(32'h8);
    chk(32'(rwd), 32'h0);
    wp(8'h00);
    host(3);
    rp();
    wp(8'h01);
    host(3);
    rf(32'h4);
    base = cnt;
    host(4);
    exp_pwr = (exp_pwr | 'h08) & 'hfd;
    pc(0, 1);
    pc(1, 1);
    rp();
    rf(32'h1);
    apb(1'b0, ufp_pkg::IRQ_EN_ADDR, 8'h00);
    chk(rd, 32'(ufp_pkg::IRQ_EN_BUSRST));
    wp(8'h08);
    rp();
    chk(32'(fen), 32'h0);
    apb(1'b0, ufp_pkg::IRQ_EN_ADDR, 8'h00);
    chk(rd, 32'(ufp_pkg::IRQ_EN_RESET));
    apb(1'b0, 12'h0fc, 8'h00);
    chk({rd[31:1], err}, 32'h1);
    wp(8'h80);
    base = cnt;
    host(5);
    host(0);
    pc(3, 1);
    pc(2, 0);
    host(1);
    pc(2, 1);
    wp(8'h00);
    host(5);
    host(0);
    pc(2, 2);
    wrap_up();
  end
endmodule : tb_usb_function_power_control
